// ---- bench/dbis_chk_sva.sv ----
// port-level assertion checker for the input staging block
`timescale 1ns/1ns
module dbis_chk (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic PREADY,
  input wire logic MEM_WORD_STROBE,
  input wire logic [dbis_pkg::WORD_W-1:0] MEM_EVEN_WORD,
  input wire logic EVEN_HOLD_LOADED,
  input wire logic ODD_HOLD_LOADED,
  input wire logic EVEN_HOLD_EMPTY,
  input wire logic ODD_HOLD_EMPTY,
  input wire logic [dbis_pkg::WORD_W-1:0] EVEN_STAGE_REG,
  input wire logic EVEN_STAGE_FULL,
  input wire logic ODD_STAGE_FULL,
  input wire logic SIDE_POINTER,
  input wire logic EVEN_STAGE_LOAD,
  input wire logic ODD_STAGE_LOAD,
  input wire logic POINTER_TOGGLE,
  input wire logic DRAIN_PULSE,
  input wire logic OUTPUT_WORD_BUFFER_FULL,
  input wire logic STAGE_ACCEPT,
  input wire logic EVEN_TO_HOLD_OK
);
  import dbis_pkg::*;
  // ==================================================
  // helpers: strobe widths are too long for a repetition
  logic any_load;
  logic sel_full;
  logic [5:0] lcnt;
  logic [5:0] dcnt;
  assign any_load = EVEN_STAGE_LOAD | ODD_STAGE_LOAD;
  assign sel_full = SIDE_POINTER ? ODD_STAGE_FULL : EVEN_STAGE_FULL;
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      lcnt <= 6'h00;
      dcnt <= 6'h00;
    end else begin
      lcnt <= any_load ? lcnt + 6'h01 : 6'h00;
      dcnt <= DRAIN_PULSE ? dcnt + 6'h01 : 6'h00;
    end
  end
  // ==================================================
  // properties
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  sequence s_load_start;
    $rose(any_load);
  endsequence
  sequence s_drain_start;
    $rose(DRAIN_PULSE);
  endsequence
  a_even_set_full: assert property ($rose(EVEN_STAGE_LOAD) |-> EVEN_STAGE_FULL)
    else $error("even full not set");
  a_odd_set_full: assert property ($rose(ODD_STAGE_LOAD) |-> ODD_STAGE_FULL)
    else $error("odd full not set");
  a_even_clr_time: assert property (EVEN_HOLD_LOADED |-> ##14 !EVEN_STAGE_FULL)
    else $error("even full not cleared");
  a_odd_clr_time: assert property (ODD_HOLD_LOADED |-> ##14 !ODD_STAGE_FULL)
    else $error("odd full not cleared");
  a_drain_with_load: assert property (s_drain_start |-> s_load_start)
    else $error("drain without load");
  a_read_load_ready: assert property (s_drain_start |-> $past(OUTPUT_WORD_BUFFER_FULL && STAGE_ACCEPT, 25))
    else $error("read load without ready");
  a_load_width: assert property ($fell(any_load) |-> lcnt == 6'h01 || lcnt == 6'h19)
    else $error("load strobe width");
  a_drain_width: assert property ($fell(DRAIN_PULSE) |-> dcnt == 6'h0d && !OUTPUT_WORD_BUFFER_FULL)
    else $error("drain width or buffer full");
  a_ptr_flip: assert property ($fell(POINTER_TOGGLE) |-> SIDE_POINTER != $past(SIDE_POINTER))
    else $error("pointer not flipped");
  a_accept_empty: assert property (STAGE_ACCEPT |-> !sel_full)
    else $error("accept while full");
  a_mem_data: assert property ($rose(EVEN_STAGE_LOAD) && $past(MEM_WORD_STROBE) |->
    EVEN_STAGE_REG == $past(MEM_EVEN_WORD))
    else $error("memory word lost");
  a_load_cause: assert property (s_load_start |-> DRAIN_PULSE || $past(MEM_WORD_STROBE) ||
    $past(PSEL && PENABLE && PREADY && PWRITE))
    else $error("load without cause");
  a_hold_ok: assert property (EVEN_TO_HOLD_OK |-> EVEN_STAGE_FULL && $past(EVEN_HOLD_EMPTY && ODD_HOLD_EMPTY))
    else $error("hold transfer too early");
endmodule // dbis_chk
bind dbis_top dbis_chk u_dbis_chk (
  .REF_CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PREADY, .MEM_WORD_STROBE, .MEM_EVEN_WORD, .EVEN_HOLD_LOADED,
  .ODD_HOLD_LOADED, .EVEN_HOLD_EMPTY, .ODD_HOLD_EMPTY, .EVEN_STAGE_REG, .EVEN_STAGE_FULL, .ODD_STAGE_FULL,
  .SIDE_POINTER, .EVEN_STAGE_LOAD, .ODD_STAGE_LOAD, .POINTER_TOGGLE, .DRAIN_PULSE, .OUTPUT_WORD_BUFFER_FULL,
  .STAGE_ACCEPT, .EVEN_TO_HOLD_OK
);

// ---- bench/dbis_mem_model.sv ----
// cache-side model: one memory word strobe per request after a chosen latency
`timescale 1ns/1ns
module dbis_mem_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic req,
  input wire logic [3:0] lat,
  input wire logic [dbis_pkg::WORD_W-1:0] word,
  output logic strobe,
  output logic [dbis_pkg::WORD_W-1:0] even_word,
  output logic [dbis_pkg::WORD_W-1:0] odd_word
);
  import dbis_pkg::*;
  logic [4:0] cnt;
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt <= 5'h00;
      strobe <= 1'b0;
      even_word <= 16'h0000;
      odd_word <= 16'hffff;
    end else begin
      cnt <= req ? {1'b0, lat} + 5'h01 : (cnt != 5'h00 ? cnt - 5'h01 : 5'h00);
      strobe <= cnt == 5'h01;
      // released lines must not keep the last word
      even_word <= (cnt == 5'h01) ? word : ~even_word;
      odd_word <= (cnt == 5'h01) ? ~word : ~odd_word;
    end
  end
endmodule // dbis_mem_model

// ---- bench/dbis_top_tb.sv ----
// self-checking bench for the input staging block
`timescale 1ns/1ns
module dbis_top_tb;
  import dbis_pkg::*;
  typedef struct {
    logic [31:0] ctrl;
    int act;
    logic [15:0] dat;
    logic [31:0] stg;
    logic [31:0] sts;
  } dbis_row_s;
  // act: 0 host word, 1 even hold copy, 2 odd hold copy, 3 memory word
  dbis_row_s rows[8] = '{
    '{32'h0000_0018, 0, 16'h1234, 32'h0000_1234, 32'h0000_0015},
    '{32'h0000_0008, 0, 16'habcd, 32'habcd_1234, 32'h0000_0003},
    '{32'h0000_0008, 1, 16'h0000, 32'habcd_1234, 32'h0000_0012},
    '{32'h0000_0008, 2, 16'h0000, 32'habcd_1234, 32'h0000_0010},
    '{32'h0000_0012, 3, 16'h5a5a, 32'habcd_5a5a, 32'h0000_0015},
    '{32'h0000_0002, 3, 16'h0f0f, 32'hf0f0_5a5a, 32'h0000_0003},
    '{32'h0000_0016, 3, 16'h3c3c, 32'hc3c3_3c3c, 32'h0000_0007},
    '{32'h0000_0010, 3, 16'h7777, 32'hc3c3_3c3c, 32'h0000_0010}
  };
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0000_0000;
  logic [31:0] prd, rd;
  logic prdy, perr, er, drdy, mstb, ef, of, sp, el, ol, pt, dp, obf, acc, eok;
  logic mreq = 1'b0, dval = 1'b0, ehl = 1'b0, ohl = 1'b0, heh = 1'b1, hoe = 1'b1;
  logic [15:0] dwd = 16'h0000, mwd = 16'h0000, mev, mow, es, os;
  logic [3:0] mlat = 4'h0;
  int n_errors = 0, checks = 0, n, k;
  dbis_top u_dbis_top (
    .REF_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd),
    .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .DRIVE_WORD(dwd), .DRIVE_VALID(dval), .DRIVE_READY(drdy),
    .MEM_WORD_STROBE(mstb), .MEM_EVEN_WORD(mev), .MEM_ODD_WORD(mow), .EVEN_HOLD_LOADED(ehl),
    .ODD_HOLD_LOADED(ohl), .EVEN_HOLD_EMPTY(heh), .ODD_HOLD_EMPTY(hoe), .EVEN_STAGE_REG(es),
    .ODD_STAGE_REG(os), .EVEN_STAGE_FULL(ef), .ODD_STAGE_FULL(of), .SIDE_POINTER(sp), .EVEN_STAGE_LOAD(el),
    .ODD_STAGE_LOAD(ol), .POINTER_TOGGLE(pt), .DRAIN_PULSE(dp), .OUTPUT_WORD_BUFFER_FULL(obf),
    .STAGE_ACCEPT(acc), .EVEN_TO_HOLD_OK(eok)
  );
  dbis_mem_model u_dbis_mem_model (
    .clk(clk), .srst(srst), .req(mreq), .lat(mlat), .word(mwd), .strobe(mstb), .even_word(mev), .odd_word(mow)
  );
  always #2 clk = ~clk;
  // ==================================================
  // tasks
  task automatic close_out;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 50);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n == 50) n_errors++;
  endtask
  task automatic pulse(input logic e, input logic o);
    @(posedge clk);
    ehl <= e;
    ohl <= o;
    @(posedge clk);
    ehl <= 1'b0;
    ohl <= 1'b0;
  endtask
  task automatic mem(input logic [15:0] w, input logic [3:0] l);
    @(posedge clk);
    mreq <= 1'b1;
    mwd <= w;
    mlat <= l;
    @(posedge clk);
    mreq <= 1'b0;
  endtask
  // ==================================================
  // watchdog and main sequence
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0010, "reset status");
    $display("reset test done");
    foreach (rows[i]) begin
      apb(1'b1, CTRL_OFS, rows[i].ctrl);
      case (rows[i].act)
        0: apb(1'b1, DATABUF_OFS, {16'h0000, rows[i].dat});
        1: pulse(1'b1, 1'b0);
        2: pulse(1'b0, 1'b1);
        default: mem(rows[i].dat, 4'(i));
      endcase
      repeat (20) @(posedge clk);
      apb(1'b0, STAGE_OFS, 32'h0000_0000);
      chk(rd, rows[i].stg, "stage");
      apb(1'b0, STATUS_OFS, 32'h0000_0000);
      chk(rd, rows[i].sts, "status");
      $display("row %0d done", i);
    end
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk({rd[30:0], er}, 32'h0000_0001, "unmapped read");
    $display("unmapped test done");
    apb(1'b1, CTRL_OFS, 32'h0000_0011);
    for (int w = 0; w < 2; w++) begin
      @(posedge clk);
      dwd <= 16'h0100 + 16'(w);
      dval <= 1'b1;
      @(posedge clk);
      dval <= 1'b0;
      n = 0;
      while (el !== 1'b1 && ol !== 1'b1 && n < 99) begin
        @(posedge clk);
        n++;
      end
      chk(32'(n > 22 && n < 30), 32'h0000_0001, "load delay");
      chk({os, es}, w ? 32'h0101_0100 : 32'hc3c3_0100, "read word");
      repeat (40) @(posedge clk);
      chk({30'h0000_0000, sp, obf}, w ? 32'h0000_0000 : 32'h0000_0002, "side and buffer");
    end
    $display("read test done");
    dwd <= 16'h0200;
    dval <= 1'b1;
    k = 0;
    repeat (40) begin
      @(posedge clk);
      if (drdy === 1'b1) begin
        k++;
        dwd <= 16'h0200 + 16'(k);
      end
    end
    dval <= 1'b0;
    chk(k, 32'h0000_0011, "fill count");
    repeat (9) begin
      pulse(1'b1, 1'b1);
      repeat (140) @(posedge clk);
    end
    chk({14'h0000, drdy, obf, es}, 32'h0002_0210, "drained");
    chk({29'h0000_0000, ef, of, acc}, 32'h0000_0005, "flag ports");
    $display("buffer test done");
    apb(1'b1, CTRL_OFS, 32'h0000_0002);
    repeat (2) @(posedge clk);
    chk({31'h0000_0000, eok}, 32'h0000_0001, "hold ok");
    hoe <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0000_0000, eok}, 32'h0000_0000, "hold busy");
    hoe <= 1'b1;
    heh <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0000_0000, eok}, 32'h0000_0000, "even hold busy");
    heh <= 1'b1;
    $display("hold test done");
    close_out();
  end
endmodule // dbis_top_tb

// ---- design/dbis_top.sv ----
// staging fifo and input staging control with its apb register file
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
// ==================================================
// fifo between the drive side and the output word buffer
module dbis_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } dbis_fifo_s;
  dbis_fifo_s st_reg;
  dbis_fifo_s st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready = (st_reg.count != (AW+1)'(DEPTH));
  assign out_valid = (st_reg.count != '0);
  assign out_data = mem[st_reg.rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wr_ptr = (st_reg.wr_ptr == AW'(DEPTH - 1)) ? '0 : st_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_next.rd_ptr = (st_reg.rd_ptr == AW'(DEPTH - 1)) ? '0 : st_reg.rd_ptr + 1'b1;
    end
    case ({push, pop})
      2'b10: st_next.count = st_reg.count + 1'b1;
      2'b01: st_next.count = st_reg.count - 1'b1;
      default: st_next.count = st_reg.count;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // storage has no reset; only words counted by the pointers are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[st_reg.wr_ptr] <= in_data;
    end
  end
endmodule // dbis_fifo

// ==================================================
// input staging control
// Notes on behaviour
// - a load strobe on either staging register sets that register's full flag.
// - even full flag clears on init or about 50 ns after even hold copy.
// - odd full flag clears on init or about 50 ns after odd hold copy.
// - read: wait for output buffer full and accept, load strobe 100 ns later.
// - accept is true only when the pointer-selected staging register is empty.
// - read: output buffer word goes to the side the pointer selects.
// - drain pulse starts with read load, ends 50 ns later clearing buffer full.
// - read load strobe lasts about 100 ns, ending at 200 ns from start.
// - every load strobe pulses toggle; pointer flips on the toggle trailing edge.
// - maintenance: host writes data register; word lands on the pointer side.
// - after init first host word goes even, the next one odd.
// - write or check: memory data loads on the memory word strobe or on a maintenance host write to the data register.
// - memory data loads only while a write or check command is active.
// - double-word flag set: one memory strobe loads both staging registers.
// - double-word flag clear: memory strobe loads only the pointer-selected side.
// - read words pass drive stage, output buffer, staging, then hold register.
// - even word may move to hold only when full and both holds empty.
module dbis_top (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [dbis_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [dbis_pkg::WORD_W-1:0] DRIVE_WORD,
  input wire logic DRIVE_VALID,
  output logic DRIVE_READY,
  input wire logic MEM_WORD_STROBE,
  input wire logic [dbis_pkg::WORD_W-1:0] MEM_EVEN_WORD,
  input wire logic [dbis_pkg::WORD_W-1:0] MEM_ODD_WORD,
  input wire logic EVEN_HOLD_LOADED,
  input wire logic ODD_HOLD_LOADED,
  input wire logic EVEN_HOLD_EMPTY,
  input wire logic ODD_HOLD_EMPTY,
  output logic [dbis_pkg::WORD_W-1:0] EVEN_STAGE_REG,
  output logic [dbis_pkg::WORD_W-1:0] ODD_STAGE_REG,
  output logic EVEN_STAGE_FULL,
  output logic ODD_STAGE_FULL,
  output logic SIDE_POINTER,
  output logic EVEN_STAGE_LOAD,
  output logic ODD_STAGE_LOAD,
  output logic POINTER_TOGGLE,
  output logic DRAIN_PULSE,
  output logic OUTPUT_WORD_BUFFER_FULL,
  output logic STAGE_ACCEPT,
  output logic EVEN_TO_HOLD_OK
);
  import dbis_pkg::*;

  typedef struct packed {
    logic [WORD_W-1:0] even_data;
    logic [WORD_W-1:0] odd_data;
    logic [WORD_W-1:0] output_word_buffer_data;
    logic [31:0] prdata;
    logic even_full;
    logic odd_full;
    logic side_ptr;
    logic output_word_buffer_full;
    logic even_load;
    logic odd_load;
    logic toggle;
    logic drain;
    logic accept;
    logic xfer_ok;
    logic seq_on;
    logic seq_side;
    logic [5:0] seq_cnt;
    logic even_clr_on;
    logic odd_clr_on;
    logic [3:0] even_clr_cnt;
    logic [3:0] odd_clr_cnt;
    logic read_cmd;
    logic write_or_check_cmd;
    logic double_word_flag;
    logic maint;
    logic pready;
    logic pslverr;
  } dbis_state_s;

  dbis_state_s st_reg;
  dbis_state_s st_next;
  logic [WORD_W-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic apb_done;
  logic register_write_strobe;
  logic buffer_reg_select;
  logic buffer_init;
  logic load_even;
  logic load_odd;
  logic set_even;
  logic set_odd;
  logic clr_even;
  logic clr_odd;

  // ==================================================
  // drive-side stage ahead of the output word buffer
  dbis_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_drive_input_stage (
    .clk(REF_CLK),
    .srst(SRST),
    .in_data(DRIVE_WORD),
    .in_valid(DRIVE_VALID),
    .in_ready(DRIVE_READY),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // the buffer refills only when empty, so a stalled sequence backs up the fifo
  assign fifo_pop = fifo_valid & ~st_reg.output_word_buffer_full;

  // ==================================================
  // apb decode
  assign apb_done = PSEL & PENABLE & st_reg.pready;
  assign register_write_strobe = apb_done & PWRITE;
  assign buffer_reg_select = (PADDR == DATABUF_OFS);
  assign buffer_init = register_write_strobe & (PADDR == CTRL_OFS) & PWDATA[CTRL_INIT_BIT];

  // ==================================================
  // next state
  always_comb begin
    st_next = st_reg;
    load_even = 1'b0;
    load_odd = 1'b0;
    clr_even = 1'b0;
    clr_odd = 1'b0;

    // apb: one wait state, answer on the second access cycle
    st_next.pready = PSEL & PENABLE & ~st_reg.pready;
    st_next.pslverr = 1'b0;
    st_next.prdata = RD_ZERO;
    if (PSEL & PENABLE & ~st_reg.pready) begin
      st_next.pslverr = ~((PADDR == CTRL_OFS) | (PADDR == DATABUF_OFS) | (PADDR == STATUS_OFS) |
                          (PADDR == STAGE_OFS));
      if (!PWRITE) begin
        case (PADDR)
          CTRL_OFS: begin
            st_next.prdata[CTRL_READ_BIT] = st_reg.read_cmd;
            st_next.prdata[CTRL_WCC_BIT] = st_reg.write_or_check_cmd;
            st_next.prdata[CTRL_DBL_BIT] = st_reg.double_word_flag;
            st_next.prdata[CTRL_MAINT_BIT] = st_reg.maint;
          end
          STATUS_OFS: begin
            st_next.prdata[ST_EVEN_FULL_BIT] = st_reg.even_full;
            st_next.prdata[ST_ODD_FULL_BIT] = st_reg.odd_full;
            st_next.prdata[ST_SIDE_BIT] = st_reg.side_ptr;
            st_next.prdata[ST_OUTPUT_WORD_BUFFER_FULL_BIT] = st_reg.output_word_buffer_full;
            st_next.prdata[ST_ACCEPT_BIT] = st_reg.accept;
            st_next.prdata[ST_SEQ_BIT] = st_reg.seq_on;
          end
          STAGE_OFS: st_next.prdata = {st_reg.odd_data, st_reg.even_data};
          default: st_next.prdata = RD_ZERO;
        endcase
      end
    end
    if (register_write_strobe & (PADDR == CTRL_OFS)) begin
      st_next.read_cmd = PWDATA[CTRL_READ_BIT];
      st_next.write_or_check_cmd = PWDATA[CTRL_WCC_BIT];
      st_next.double_word_flag = PWDATA[CTRL_DBL_BIT];
      st_next.maint = PWDATA[CTRL_MAINT_BIT];
    end

    // output word buffer takes the fifo head when empty
    if (fifo_pop) begin
      st_next.output_word_buffer_full = 1'b1;
      st_next.output_word_buffer_data = fifo_data;
    end

    // read sequence: delay-line taps counted in clocks
    if (st_reg.seq_on) begin
      st_next.seq_cnt = st_reg.seq_cnt + 1'b1;
      if (st_reg.seq_cnt == SEQ_LOAD_ON - 6'd1) begin
        load_even = ~st_reg.seq_side;
        load_odd = st_reg.seq_side;
        st_next.drain = 1'b1;
      end
      if (st_reg.seq_cnt == SEQ_DRAIN_OFF - 6'd1) begin
        st_next.drain = 1'b0;
        st_next.output_word_buffer_full = 1'b0;
      end
      if (st_reg.seq_cnt == SEQ_LOAD_OFF - 6'd1) begin
        st_next.even_load = 1'b0;
        st_next.odd_load = 1'b0;
        st_next.seq_on = 1'b0;
      end
    end else if (st_reg.read_cmd & st_reg.output_word_buffer_full & st_reg.accept) begin
      st_next.seq_on = 1'b1;
      st_next.seq_cnt = 6'd1;
      st_next.seq_side = st_reg.side_ptr;
    end else begin
      // single-cycle strobes from memory or host end after one clock
      st_next.even_load = 1'b0;
      st_next.odd_load = 1'b0;
      if (st_reg.write_or_check_cmd & MEM_WORD_STROBE) begin
        if (st_reg.double_word_flag) begin
          load_even = 1'b1;
          load_odd = 1'b1;
        end else begin
          load_even = ~st_reg.side_ptr;
          load_odd = st_reg.side_ptr;
        end
      end else if (st_reg.maint & register_write_strobe & buffer_reg_select) begin
        load_even = ~st_reg.side_ptr;
        load_odd = st_reg.side_ptr;
      end
    end

    // staging data capture at the strobe's leading edge
    if (load_even) begin
      st_next.even_load = 1'b1;
      if (st_reg.seq_on) begin
        st_next.even_data = st_reg.output_word_buffer_data;
      end else if (st_reg.write_or_check_cmd) begin
        st_next.even_data = MEM_EVEN_WORD;
      end else begin
        st_next.even_data = PWDATA[WORD_W-1:0];
      end
    end
    if (load_odd) begin
      st_next.odd_load = 1'b1;
      if (st_reg.seq_on) begin
        st_next.odd_data = st_reg.output_word_buffer_data;
      end else if (st_reg.write_or_check_cmd) begin
        st_next.odd_data = MEM_ODD_WORD;
      end else begin
        st_next.odd_data = PWDATA[WORD_W-1:0];
      end
    end

    // pointer flips as the toggle pulse falls
    st_next.toggle = st_next.even_load | st_next.odd_load;
    if (st_reg.toggle & ~st_next.toggle) begin
      st_next.side_ptr = ~st_reg.side_ptr;
    end

    // full flag clear timers started by the hold register copy
    if (EVEN_HOLD_LOADED) begin
      st_next.even_clr_on = 1'b1;
      st_next.even_clr_cnt = 4'd1;
    end else if (st_reg.even_clr_on) begin
      st_next.even_clr_cnt = st_reg.even_clr_cnt + 1'b1;
      if (st_reg.even_clr_cnt == CLR_WAIT) begin
        clr_even = 1'b1;
        st_next.even_clr_on = 1'b0;
      end
    end
    if (ODD_HOLD_LOADED) begin
      st_next.odd_clr_on = 1'b1;
      st_next.odd_clr_cnt = 4'd1;
    end else if (st_reg.odd_clr_on) begin
      st_next.odd_clr_cnt = st_reg.odd_clr_cnt + 1'b1;
      if (st_reg.odd_clr_cnt == CLR_WAIT) begin
        clr_odd = 1'b1;
        st_next.odd_clr_on = 1'b0;
      end
    end

    // clear is written last so it wins over a coincident set
    if (load_even) begin
      st_next.even_full = 1'b1;
    end
    if (load_odd) begin
      st_next.odd_full = 1'b1;
    end
    if (clr_even) begin
      st_next.even_full = 1'b0;
    end
    if (clr_odd) begin
      st_next.odd_full = 1'b0;
    end

    // buffer initialize returns staging and the output word buffer to their empty, even state
    if (buffer_init) begin
      st_next.even_full = 1'b0;
      st_next.odd_full = 1'b0;
      st_next.side_ptr = SIDE_EVEN;
      st_next.output_word_buffer_full = 1'b0;
      st_next.seq_on = 1'b0;
      st_next.even_load = 1'b0;
      st_next.odd_load = 1'b0;
      st_next.toggle = 1'b0;
      st_next.drain = 1'b0;
      st_next.even_clr_on = 1'b0;
      st_next.odd_clr_on = 1'b0;
    end

    st_next.accept = (st_next.side_ptr == SIDE_ODD) ? ~st_next.odd_full : ~st_next.even_full;
    st_next.xfer_ok = st_next.write_or_check_cmd & st_next.even_full &
                      EVEN_HOLD_EMPTY & ODD_HOLD_EMPTY;
  end

  // ==================================================
  // state register
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign PRDATA = st_reg.prdata;
  assign PREADY = st_reg.pready;
  assign PSLVERR = st_reg.pslverr;
  assign EVEN_STAGE_REG = st_reg.even_data;
  assign ODD_STAGE_REG = st_reg.odd_data;
  assign EVEN_STAGE_FULL = st_reg.even_full;
  assign ODD_STAGE_FULL = st_reg.odd_full;
  assign SIDE_POINTER = st_reg.side_ptr;
  assign EVEN_STAGE_LOAD = st_reg.even_load;
  assign ODD_STAGE_LOAD = st_reg.odd_load;
  assign POINTER_TOGGLE = st_reg.toggle;
  assign DRAIN_PULSE = st_reg.drain;
  assign OUTPUT_WORD_BUFFER_FULL = st_reg.output_word_buffer_full;
  assign STAGE_ACCEPT = st_reg.accept;
  assign EVEN_TO_HOLD_OK = st_reg.xfer_ok;
endmodule // dbis_top

// ---- include/dbis_pkg.sv ----
// shared constants for the data buffer input staging block
package dbis_pkg;
  // ==================================================
  // data path
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int ADDR_W = 8;
  // ==================================================
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int LOAD_START_NS = 100;
  localparam int DRAIN_END_NS = 150;
  localparam int LOAD_END_NS = 200;
  localparam int FULL_CLR_NS = 50;
  localparam int LOAD_START_CYC = (LOAD_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DRAIN_END_CYC = (DRAIN_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_END_CYC = LOAD_END_NS / CLK_PERIOD_NS;
  localparam int FULL_CLR_CYC = (FULL_CLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] SEQ_LOAD_ON = 6'(LOAD_START_CYC);
  localparam logic [5:0] SEQ_DRAIN_OFF = 6'(DRAIN_END_CYC);
  localparam logic [5:0] SEQ_LOAD_OFF = 6'(LOAD_END_CYC);
  localparam logic [3:0] CLR_WAIT = 4'(FULL_CLR_CYC);
  // ==================================================
  // register map (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DATABUF_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] STAGE_OFS = 8'h0C;
  // control fields
  localparam int CTRL_READ_BIT = 0;
  localparam int CTRL_WCC_BIT = 1;
  localparam int CTRL_DBL_BIT = 2;
  localparam int CTRL_MAINT_BIT = 3;
  localparam int CTRL_INIT_BIT = 4;
  // status fields
  localparam int ST_EVEN_FULL_BIT = 0;
  localparam int ST_ODD_FULL_BIT = 1;
  localparam int ST_SIDE_BIT = 2;
  localparam int ST_OUTPUT_WORD_BUFFER_FULL_BIT = 3;
  localparam int ST_ACCEPT_BIT = 4;
  localparam int ST_SEQ_BIT = 5;
  // reset values
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  localparam logic SIDE_EVEN = 1'b0;
  localparam logic SIDE_ODD = 1'b1;
endpackage
